// ==== hdl/acis_pkg.sv ====
package acis_pkg;
    // Register map: one 16-bit register, offset of our own choosing
    localparam int ADDR_W = 4;
    localparam logic [3:0] SEL_REG_ADDR = 4'h0;
    localparam int DATA_W = 16;
    localparam logic [15:0] SEL_RESET = 16'h0000;
    localparam logic [15:0] SEL_WMASK = 16'h0707;
    // Field positions
    localparam int NB_HI = 10;
    localparam int NB_LO = 9;
    localparam int SB_BIT = 8;
    localparam int NA_HI = 2;
    localparam int NA_LO = 1;
    localparam int SA_BIT = 0;
    // Positive-input pin numbers per channel (pin index 0..5, 7 = not connected)
    localparam logic [2:0] PIN_NC = 3'h7;
    localparam logic [2:0] PIN_0 = 3'h0;
    localparam logic [2:0] PIN_1 = 3'h1;
    localparam logic [2:0] PIN_2 = 3'h2;
    localparam logic [2:0] PIN_3 = 3'h3;
    localparam logic [2:0] PIN_4 = 3'h4;
    localparam logic [2:0] PIN_5 = 3'h5;
    typedef enum logic [1:0] {
        ACIS_NEG_GND = 2'b00,
        ACIS_NEG_RSV = 2'b10
    } acis_neg_t;
endpackage : acis_pkg

// ==== hdl/acis_route.sv ====
`timescale 1ns/100ps
// Decodes one sample's select fields into per-channel routing codes
module acis_route (
    input wire logic large_variant,
    input wire logic pos_sel,
    input wire logic [1:0] neg_sel,
    output logic [2:0] ch1_pos,
    output logic [2:0] ch2_pos,
    output logic [2:0] ch3_pos,
    output logic neg_ground,
    output logic neg_reserved
);
    always_comb begin
        neg_ground = ~neg_sel[1];
        neg_reserved = neg_sel[1];
        if (!pos_sel) begin
            ch1_pos = acis_pkg::PIN_0;
            ch2_pos = acis_pkg::PIN_1;
            ch3_pos = acis_pkg::PIN_2;
        end else if (large_variant) begin
            ch1_pos = acis_pkg::PIN_3;
            ch2_pos = acis_pkg::PIN_4;
            ch3_pos = acis_pkg::PIN_5;
        end else begin
            ch1_pos = acis_pkg::PIN_3;
            ch2_pos = acis_pkg::PIN_NC;
            ch3_pos = acis_pkg::PIN_NC;
        end
    end
endmodule : acis_route

// ==== hdl/acis_top.sv ====
`timescale 1ns/100ps
// Behaviour
// - Sample B negative field bits 10-9 ground negative inputs when upper bit is 0.
// - Small variant: sample B positive bit set routes ch1 to pin 3, others open.
// - Large variant: sample B positive bit set routes channels to pins 3, 4, 5.
// - Sample A negative field bits 2-1 ground negative inputs when upper bit is 0.
// - Small variant: sample A positive bit set routes ch1 to pin 3, others open.
// - Bits 15-11 and 7-3 read zero; all select bits reset to zero.
module acis_top #(
    parameter bit LARGE_VARIANT = 1'b0
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic alt_sample_b,
    output logic [15:0] reg_rdata,
    output logic [2:0] ch1_pos_sel,
    output logic [2:0] ch2_pos_sel,
    output logic [2:0] ch3_pos_sel,
    output logic neg_analog_ground,
    output logic neg_reserved_code
);
    logic [15:0] sel_reg, sel_next;
    logic [15:0] rdata_reg, rdata_next;
    logic [2:0] c1_reg, c2_reg, c3_reg;
    logic [2:0] c1_next, c2_next, c3_next;
    logic gnd_reg, rsv_reg;
    logic gnd_next, rsv_next;
    logic [2:0] a1, a2, a3, b1, b2, b3;
    logic a_gnd, a_rsv, b_gnd, b_rsv;
    logic sel_hit_wr, sel_hit_rd;

    // Only one offset is mapped; any other address reads zero and ignores writes
    function automatic logic sel_hit(input logic [3:0] addr);
        sel_hit = (addr == acis_pkg::SEL_REG_ADDR);
    endfunction : sel_hit

    // Ports are fixed at 16 data and 4 address bits
    if (acis_pkg::DATA_W != 16) begin : g_bad_data_w
        $error("register width must be 16 bits");
    end
    if (acis_pkg::ADDR_W != 4) begin : g_bad_addr_w
        $error("address width must be 4 bits");
    end
    // Fields must lie inside the word in their fixed order, without overlap
    if (acis_pkg::NB_HI >= acis_pkg::DATA_W) begin : g_bad_nb_pos
        $error("sample B negative field lies outside the register");
    end
    if (acis_pkg::SB_BIT >= acis_pkg::NB_LO) begin : g_bad_sb_pos
        $error("sample B positive bit overlaps its negative field");
    end
    if (acis_pkg::NA_HI >= acis_pkg::SB_BIT) begin : g_bad_na_pos
        $error("sample A negative field overlaps sample B");
    end
    if (acis_pkg::SA_BIT >= acis_pkg::NA_LO) begin : g_bad_sa_pos
        $error("sample A positive bit overlaps its negative field");
    end

    acis_route u_route_a (
        .large_variant(LARGE_VARIANT),
        .pos_sel(sel_reg[acis_pkg::SA_BIT]),
        .neg_sel(sel_reg[acis_pkg::NA_HI:acis_pkg::NA_LO]),
        .ch1_pos(a1),
        .ch2_pos(a2),
        .ch3_pos(a3),
        .neg_ground(a_gnd),
        .neg_reserved(a_rsv)
    );
    acis_route u_route_b (
        .large_variant(LARGE_VARIANT),
        .pos_sel(sel_reg[acis_pkg::SB_BIT]),
        .neg_sel(sel_reg[acis_pkg::NB_HI:acis_pkg::NB_LO]),
        .ch1_pos(b1),
        .ch2_pos(b2),
        .ch3_pos(b3),
        .neg_ground(b_gnd),
        .neg_reserved(b_rsv)
    );

    always_comb begin
        sel_hit_wr = reg_wr && sel_hit(reg_addr);
        sel_hit_rd = reg_rd && sel_hit(reg_addr);
        sel_next = sel_reg;
        rdata_next = 16'h0000;
        // Unimplemented bits are never stored, so reads see zero
        if (sel_hit_wr) begin
            sel_next = reg_wdata & acis_pkg::SEL_WMASK;
        end
        if (sel_hit_rd) begin
            rdata_next = sel_reg & acis_pkg::SEL_WMASK;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sel_reg <= acis_pkg::SEL_RESET;
            rdata_reg <= 16'h0000;
        end else begin
            sel_reg <= sel_next;
            rdata_reg <= rdata_next;
        end
    end

    // Sample pick follows the alternate-sample level from the neighbouring sequencer
    always_comb begin
        if (alt_sample_b) begin
            c1_next = b1;
            c2_next = b2;
            c3_next = b3;
            gnd_next = b_gnd;
            rsv_next = b_rsv;
        end else begin
            c1_next = a1;
            c2_next = a2;
            c3_next = a3;
            gnd_next = a_gnd;
            rsv_next = a_rsv;
        end
    end

    // Registered routing costs one cycle but keeps the analog switch controls glitch-free
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            // Same routing as an all-zero register
            c1_reg <= acis_pkg::PIN_0;
            c2_reg <= acis_pkg::PIN_1;
            c3_reg <= acis_pkg::PIN_2;
            gnd_reg <= 1'h1;
            rsv_reg <= 1'h0;
        end else begin
            c1_reg <= c1_next;
            c2_reg <= c2_next;
            c3_reg <= c3_next;
            gnd_reg <= gnd_next;
            rsv_reg <= rsv_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign ch1_pos_sel = c1_reg;
    assign ch2_pos_sel = c2_reg;
    assign ch3_pos_sel = c3_reg;
    assign neg_analog_ground = gnd_reg;
    assign neg_reserved_code = rsv_reg;

    chk_reserved_zero: assert property (@(posedge sys_clk) disable iff (srst)
        (sel_reg & ~acis_pkg::SEL_WMASK) == 16'h0000)
        else $error("unimplemented select bits hold a one");

    chk_write_lands: assert property (@(posedge sys_clk) disable iff (srst)
        sel_hit_wr
        |=> sel_reg == ($past(reg_wdata) & acis_pkg::SEL_WMASK))
        else $error("register write did not land");

    chk_unmapped_hold: assert property (@(posedge sys_clk) disable iff (srst)
        reg_wr && !sel_hit(reg_addr)
        |=> $stable(sel_reg))
        else $error("write to an unmapped address changed the register");

    chk_sel_hold: assert property (@(posedge sys_clk) disable iff (srst)
        !sel_hit_wr
        |=> $stable(sel_reg))
        else $error("register changed without a write");

    chk_read_data: assert property (@(posedge sys_clk) disable iff (srst)
        reg_rd && reg_addr == acis_pkg::SEL_REG_ADDR && !reg_wr
        |=> reg_rdata == ($past(sel_reg) & acis_pkg::SEL_WMASK))
        else $error("read data mismatch");

    chk_rdata_idle: assert property (@(posedge sys_clk) disable iff (srst)
        !sel_hit_rd
        |=> reg_rdata == 16'h0000)
        else $error("read data not zero outside a mapped read");

    chk_reset_route: assert property (@(posedge sys_clk)
        srst
        |=> reg_rdata == 16'h0000 && neg_analog_ground && !neg_reserved_code
            && ch1_pos_sel == acis_pkg::PIN_0 && ch2_pos_sel == acis_pkg::PIN_1
            && ch3_pos_sel == acis_pkg::PIN_2)
        else $error("outputs not at reset values after reset");

    chk_b_neg_gnd: assert property (@(posedge sys_clk) disable iff (srst)
        alt_sample_b |=> neg_analog_ground == !$past(sel_reg[acis_pkg::NB_HI]))
        else $error("sample B negative select wrong");

    chk_b_neg_rsv: assert property (@(posedge sys_clk) disable iff (srst)
        alt_sample_b
        |=> neg_reserved_code == $past(sel_reg[acis_pkg::NB_HI]))
        else $error("sample B reserved code flag wrong");

    chk_a_neg_gnd: assert property (@(posedge sys_clk) disable iff (srst)
        !alt_sample_b |=> neg_analog_ground == !$past(sel_reg[acis_pkg::NA_HI]))
        else $error("sample A negative select wrong");

    chk_a_neg_rsv: assert property (@(posedge sys_clk) disable iff (srst)
        !alt_sample_b
        |=> neg_reserved_code == $past(sel_reg[acis_pkg::NA_HI]))
        else $error("sample A reserved code flag wrong");

    chk_b_small_set: assert property (@(posedge sys_clk) disable iff (srst)
        !LARGE_VARIANT && alt_sample_b && sel_reg[acis_pkg::SB_BIT]
        |=> ch1_pos_sel == 3'h3 && ch2_pos_sel == 3'h7 && ch3_pos_sel == 3'h7)
        else $error("small variant sample B routing wrong");

    chk_b_large_set: assert property (@(posedge sys_clk) disable iff (srst)
        LARGE_VARIANT && alt_sample_b && sel_reg[acis_pkg::SB_BIT]
        |=> ch1_pos_sel == 3'h3 && ch2_pos_sel == 3'h4 && ch3_pos_sel == 3'h5)
        else $error("large variant sample B routing wrong");

    chk_b_clear_route: assert property (@(posedge sys_clk) disable iff (srst)
        alt_sample_b && !sel_reg[acis_pkg::SB_BIT]
        |=> ch1_pos_sel == 3'h0 && ch2_pos_sel == 3'h1 && ch3_pos_sel == 3'h2)
        else $error("sample B default routing wrong");

    chk_a_small_set: assert property (@(posedge sys_clk) disable iff (srst)
        !LARGE_VARIANT && !alt_sample_b && sel_reg[acis_pkg::SA_BIT]
        |=> ch1_pos_sel == 3'h3 && ch2_pos_sel == 3'h7 && ch3_pos_sel == 3'h7)
        else $error("small variant sample A routing wrong");

    chk_a_large_set: assert property (@(posedge sys_clk) disable iff (srst)
        LARGE_VARIANT && !alt_sample_b && sel_reg[acis_pkg::SA_BIT]
        |=> ch1_pos_sel == 3'h3 && ch2_pos_sel == 3'h4 && ch3_pos_sel == 3'h5)
        else $error("large variant sample A routing wrong");

    chk_a_clear_route: assert property (@(posedge sys_clk) disable iff (srst)
        !alt_sample_b && !sel_reg[acis_pkg::SA_BIT]
        |=> ch1_pos_sel == 3'h0 && ch2_pos_sel == 3'h1 && ch3_pos_sel == 3'h2)
        else $error("sample A default routing wrong");
endmodule : acis_top

// ==== verification/acis_tb.sv ====
`timescale 1ns/100ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_total++; \
    $display("unexpected %0t: got %h want %h", $time, (a), (b)); end end
module tb;
    logic sys_clk, srst, reg_wr, reg_rd, alt_sample_b;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata, rdata_s, rdata_l, v;
    logic [2:0] s1, s2, s3, l1, l2, l3, f;
    logic gnd_s, rsv_s, gnd_l, rsv_l;
    int err_total = 0;
    int num_checks = 0;
    // Both variants side by side so every write exercises both pin maps
    acis_top #(.LARGE_VARIANT(1'b0)) i_dut (.sys_clk(sys_clk), .srst(srst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .alt_sample_b(alt_sample_b), .reg_rdata(rdata_s), .ch1_pos_sel(s1),
        .ch2_pos_sel(s2), .ch3_pos_sel(s3), .neg_analog_ground(gnd_s),
        .neg_reserved_code(rsv_s));
    acis_top #(.LARGE_VARIANT(1'b1)) i_dut_large (.sys_clk(sys_clk), .srst(srst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .alt_sample_b(alt_sample_b), .reg_rdata(rdata_l), .ch1_pos_sel(l1),
        .ch2_pos_sel(l2), .ch3_pos_sel(l3), .neg_analog_ground(gnd_l),
        .neg_reserved_code(rsv_l));
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : complete_run
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    // Read data stands only in the cycle after the strobe is taken
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        `CHK(rdata_s, e)
        `CHK(rdata_l, e)
    endtask : rd
    task automatic chk_out(input logic [2:0] fv);
        logic [8:0] small_exp, large_exp;
        small_exp = {acis_pkg::PIN_0, acis_pkg::PIN_1, acis_pkg::PIN_2};
        large_exp = small_exp;
        if (fv[0]) begin
            small_exp = {acis_pkg::PIN_3, acis_pkg::PIN_NC, acis_pkg::PIN_NC};
            large_exp = {acis_pkg::PIN_3, acis_pkg::PIN_4, acis_pkg::PIN_5};
        end
        `CHK({s1, s2, s3}, small_exp)
        `CHK({l1, l2, l3}, large_exp)
        `CHK({gnd_s, rsv_s, gnd_l, rsv_l}, {~fv[2], fv[2], ~fv[2], fv[2]})
    endtask : chk_out
    initial begin
        #200000;
        err_total++;
        complete_run();
    end
    initial begin
        srst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        alt_sample_b = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        repeat (10) @(posedge sys_clk);
        srst <= 1'b0;
        rd(acis_pkg::SEL_REG_ADDR, 16'h0000);
        chk_out(3'h0);
        $display("reset test done");
        // Other sample's fields hold the inverse code to catch a wrong field pick
        for (int i = 0; i < 16; i++) begin
            f = i[2:0];
            v = i[3] ? {5'h1F, f, 5'h1F, ~f} : {5'h1F, ~f, 5'h1F, f};
            @(posedge sys_clk);
            alt_sample_b <= i[3];
            wr(acis_pkg::SEL_REG_ADDR, v);
            rd(acis_pkg::SEL_REG_ADDR, v & 16'h0707);
            chk_out(f);
        end
        $display("field decode test done");
        wr(4'h5, 16'h0000);
        rd(4'h5, 16'h0000);
        rd(acis_pkg::SEL_REG_ADDR, 16'h0700);
        $display("unmapped access test done");
        @(posedge sys_clk);
        srst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        rd(acis_pkg::SEL_REG_ADDR, 16'h0000);
        chk_out(3'h0);
        $display("second reset test done");
        complete_run();
    end
endmodule : tb
